/* servo_drive_fault_monitor.sv */
// Fault supervision for a servo drive with an Avalon-MM register slave.
`timescale 1ns/1ns
`default_nettype none
`include "fault_monitor_defs.svh"
module servo_drive_fault_monitor
  import fault_monitor_pkg::*;
#(
  parameter int unsigned EN_TOGGLE_CYCLES = `EN_TOGGLE_CYCLES,
  parameter int unsigned LOW_BUS_CYCLES = `LOW_BUS_CYCLES,
  parameter int unsigned ALL_ON_CYCLES = `ALL_ON_CYCLES,
  parameter int unsigned COUNTS_PER_REV = 4096,
  parameter int unsigned NVM_AW = 6,
  parameter int unsigned NVM_DW = 16,
  parameter int unsigned SPEED_W = 16,
  parameter int unsigned SHUNT_W = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [`AV_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic pwrOverTemp,
  input wire logic pwrOverCurrent,
  input wire logic pwrLogicOk,
  input wire logic driveEnable,
  input wire logic busOverVolt,
  input wire logic busUnderVolt,
  input wire logic encA,
  input wire logic encAn,
  input wire logic encB,
  input wire logic encBn,
  input wire logic encZ,
  input wire logic encZn,
  input wire logic motorThermalOpen,
  input wire logic travelPos,
  input wire logic travelNeg,
  input wire logic resetButton,
  input wire logic [SPEED_W-1:0] motorSpeed,
  input wire logic signed [31:0] positionError,
  input wire logic [SHUNT_W-1:0] shuntPowerRms,
  output logic [NVM_AW-1:0] nvmAddr,
  input wire logic [NVM_DW-1:0] nvmData,
  output logic [`FAULT_W-1:0] faultFlags,
  output logic [3:0] faultCode,
  output logic allSegmentsOn,
  output logic bridgeDisable
);
  localparam logic [31:0] FE_LIM_RESET = 32'(COUNTS_PER_REV * `FE_DEFAULT_TENTHS_REV / 10);
  localparam logic [`FAULT_W-1:0] CLEARABLE = `CLEARABLE_MASK;
  localparam logic [`FAULT_W-1:0] AUTOCLR = `AUTO_MASK;

  logic [`SYNC_W-1:0] pinSync;
  logic pmOt, pmOc, pmOk, drvEn, busOv, busUv;
  logic eA, eAn, eB, eBn, eZ, eZn, thermOpen, trvPos, trvNeg, rstBtn;

  sync_bank #(.WIDTH(`SYNC_W), .RESET_VAL(`SYNC_RESET_VAL)) uSync (
    .clk(clk),
    .reset(reset),
    .din({pwrOverTemp, pwrOverCurrent, pwrLogicOk, driveEnable, busOverVolt, busUnderVolt,
          encA, encAn, encB, encBn, encZ, encZn, motorThermalOpen, travelPos, travelNeg,
          resetButton}),
    .dout(pinSync)
  );
  assign {pmOt, pmOc, pmOk, drvEn, busOv, busUv, eA, eAn, eB, eBn, eZ, eZn,
          thermOpen, trvPos, trvNeg, rstBtn} = pinSync;

  // Register slave.
  logic waitReq_q;
  logic [31:0] readData_q;
  logic [`CTRL_W-1:0] ctrl_q;
  logic [SPEED_W-1:0] speedLimit_q;
  logic [31:0] feLimit_q;
  logic [SHUNT_W-1:0] shuntLimit_q;
  logic wrAcc;
  logic ctrlWr;
  logic swClear;
  logic rebootReq;
  logic [31:0] readMux;
  fault_vec_t faults_q;
  fault_code_t code_q;
  logic allOn_q;
  logic bridge_q;

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // One wait state on every access: the answer is ready one edge after the request appears.
  always_ff @(posedge clk) begin
    if (reset) begin
      waitReq_q <= 1'b1;
      readData_q <= 32'h00000000;
    end else if ((avs_read || avs_write) && waitReq_q) begin
      waitReq_q <= 1'b0;
      readData_q <= avs_read ? readMux : 32'h00000000;
    end else begin
      waitReq_q <= 1'b1;
    end
  end

  assign wrAcc = avs_write && !waitReq_q;
  assign ctrlWr = wrAcc && (avs_address == `OFS_CTRL);
  assign swClear = ctrlWr && avs_byteenable[1] && avs_writedata[`CTRL_CLEAR];
  assign rebootReq = ctrlWr && avs_byteenable[1] && avs_writedata[`CTRL_REBOOT];

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= `CTRL_RESET_VAL;
      speedLimit_q <= `SPEED_LIM_RESET;
      feLimit_q <= FE_LIM_RESET;
      shuntLimit_q <= `SHUNT_LIM_RESET;
    end else if (wrAcc) begin
      case (avs_address)
        `OFS_CTRL: begin
          if (avs_byteenable[0]) begin
            ctrl_q <= avs_writedata[`CTRL_W-1:0];
          end
        end
        `OFS_SPEED_LIM: begin
          speedLimit_q <= SPEED_W'(mergeBytes(32'(speedLimit_q), avs_writedata, avs_byteenable));
        end
        `OFS_FE_LIM: begin
          feLimit_q <= mergeBytes(feLimit_q, avs_writedata, avs_byteenable);
        end
        `OFS_SHUNT_LIM: begin
          shuntLimit_q <= SHUNT_W'(mergeBytes(32'(shuntLimit_q), avs_writedata, avs_byteenable));
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    case (avs_address)
      `OFS_CTRL: readMux = 32'(ctrl_q);
      `OFS_STATUS: readMux = 32'(faults_q);
      `OFS_CODE: readMux = 32'({allOn_q, 4'h0, code_q});
      `OFS_SPEED_LIM: readMux = 32'(speedLimit_q);
      `OFS_FE_LIM: readMux = feLimit_q;
      `OFS_SHUNT_LIM: readMux = 32'(shuntLimit_q);
      default: readMux = 32'h00000000;
    endcase
  end

  // Reset requests from the front-panel button (rising edge) or software.
  logic rstBtnDly_q;
  logic clearReq;
  always_ff @(posedge clk) begin
    if (reset) begin
      rstBtnDly_q <= 1'b0;
    end else begin
      rstBtnDly_q <= rstBtn;
    end
  end
  assign clearReq = (rstBtn && !rstBtnDly_q) || swClear;

  // Storage checksum: words must sum to zero; read data is valid one cycle after the address.
  nvm_state_e nvState_q;
  logic [NVM_AW-1:0] nvAddr_q;
  logic [NVM_DW-1:0] nvSum_q;
  logic [NVM_DW-1:0] nvSumNext;
  logic nvmFail;
  assign nvSumNext = nvSum_q + nvmData;
  assign nvmFail = (nvState_q == NV_ACC) && (&nvAddr_q) && (nvSumNext != '0);

  always_ff @(posedge clk) begin
    if (reset || rebootReq) begin
      nvState_q <= NV_REQ;
      nvAddr_q <= '0;
      nvSum_q <= '0;
    end else begin
      case (nvState_q)
        NV_REQ: begin
          nvState_q <= NV_ACC;
        end
        NV_ACC: begin
          nvSum_q <= nvSumNext;
          if (&nvAddr_q) begin
            nvState_q <= NV_DONE;
          end else begin
            nvAddr_q <= nvAddr_q + 1'b1;
            nvState_q <= NV_REQ;
          end
        end
        NV_DONE: begin
          nvState_q <= NV_DONE;
        end
        default: begin
          nvState_q <= NV_REQ;
        end
      endcase
    end
  end

  // Enable toggle rate: two rising edges closer than one tenth of a second.
  logic drvEnDly_q;
  logic enSeen_q;
  logic [31:0] enCnt_q;
  logic fastToggle;
  assign fastToggle = drvEn && !drvEnDly_q && enSeen_q && (enCnt_q < EN_TOGGLE_CYCLES);
  always_ff @(posedge clk) begin
    if (reset) begin
      drvEnDly_q <= 1'b0;
      enSeen_q <= 1'b0;
      enCnt_q <= 32'h00000000;
    end else begin
      drvEnDly_q <= drvEn;
      if (drvEn && !drvEnDly_q) begin
        enSeen_q <= 1'b1;
        // Starting at one makes the count equal the cycles since the last rising edge,
        // so edges exactly one limit period apart are not counted as too fast.
        enCnt_q <= 32'h00000001;
      end else if (enCnt_q < EN_TOGGLE_CYCLES) begin
        enCnt_q <= enCnt_q + 32'h00000001;
      end
    end
  end

  // Encoder quadrature sequence: a Gray code allows one line to change per sample.
  logic [1:0] quadPrev_q;
  logic encBadState;
  logic encPairBad;
  always_ff @(posedge clk) begin
    if (reset) begin
      quadPrev_q <= 2'h0;
    end else begin
      quadPrev_q <= {eA, eB};
    end
  end
  assign encBadState = ((quadPrev_q ^ {eA, eB}) == 2'h3) || (eZ && !(eA && eB));
  assign encPairBad = (eA == eAn) || (eB == eBn) || (eZ == eZn);

  logic lowBusPersist;
  logic allOnDone;
  persist_timer #(.LIMIT(LOW_BUS_CYCLES)) uLowBus (
    .clk(clk),
    .reset(reset),
    .level(busUv),
    .done(lowBusPersist)
  );
  persist_timer #(.LIMIT(ALL_ON_CYCLES)) uAllOn (
    .clk(clk),
    .reset(reset),
    .level(!rebootReq),
    .done(allOnDone)
  );

  logic [31:0] feAbs;
  fault_vec_t faultSet;
  assign feAbs = positionError[31] ? 32'(-positionError) : 32'(positionError);

  always_comb begin
    faultSet = '0;
    faultSet[`F_NVM] = nvmFail;
    faultSet[`F_PWR] = pmOt || pmOc || !pmOk || fastToggle;
    faultSet[`F_HIBUS] = busOv;
    faultSet[`F_LOBUS] = lowBusPersist && ctrl_q[`CTRL_LOWBUS_EN];
    faultSet[`F_ENCST] = encBadState && ctrl_q[`CTRL_ENCST_EN];
    faultSet[`F_ENCHW] = encPairBad;
    faultSet[`F_MOTOT] = thermOpen;
    faultSet[`F_SHUNT] = shuntPowerRms > shuntLimit_q;
    faultSet[`F_OVSPD] = motorSpeed > speedLimit_q;
    faultSet[`F_FOLERR] = ctrl_q[`CTRL_FE_EN] && (feAbs > feLimit_q);
    faultSet[`F_TRAVEL] = trvPos || trvNeg;
  end

  // A detect in the same cycle as a clear keeps the flag set.
  for (genvar gi = 0; gi < `FAULT_W; gi++) begin : gFault
    always_ff @(posedge clk) begin
      if (reset || rebootReq) begin
        faults_q[gi] <= 1'b0;
      end else if (faultSet[gi]) begin
        faults_q[gi] <= 1'b1;
      end else if (clearReq && CLEARABLE[gi]) begin
        faults_q[gi] <= 1'b0;
      end else if (AUTOCLR[gi]) begin
        faults_q[gi] <= 1'b0;
      end
    end
  end

  function automatic fault_code_t topFault(input fault_vec_t f);
    fault_code_t c;
    c = 4'h0;
    for (int i = `FAULT_W - 1; i >= 0; i--) begin
      if (f[i]) begin
        c = 4'(i + 1);
      end
    end
    return c;
  endfunction

  always_ff @(posedge clk) begin
    if (reset) begin
      code_q <= 4'h0;
      allOn_q <= 1'b1;
      bridge_q <= 1'b1;
    end else begin
      code_q <= topFault(faults_q);
      allOn_q <= !allOnDone;
      bridge_q <= !allOnDone || |(faults_q & ~AUTOCLR);
    end
  end

  assign avs_readdata = readData_q;
  assign avs_waitrequest = waitReq_q;
  assign nvmAddr = nvAddr_q;
  assign faultFlags = faults_q;
  assign faultCode = code_q;
  assign allSegmentsOn = allOn_q;
  assign bridgeDisable = bridge_q;

  sequence sFastToggle;
    fastToggle;
  endsequence
  sequence sEncFault;
    faults_q[`F_ENCST] && !rebootReq && !reset;
  endsequence

  AST_PWR_STAGE: assert property (@(posedge clk) disable iff (reset)
    (pmOt || pmOc || !pmOk) && !rebootReq |=> faults_q[`F_PWR])
    else $error("Power stage problem did not raise the power-module fault.");
  AST_FAST_TOGGLE: assert property (@(posedge clk) disable iff (reset)
    sFastToggle ##0 !rebootReq |=> faults_q[`F_PWR] ##1 code_q != 4'h0)
    else $error("Fast enable toggling did not raise the power-module fault.");
  AST_HIGH_BUS: assert property (@(posedge clk) disable iff (reset)
    busOv && !rebootReq |=> faults_q[`F_HIBUS])
    else $error("Bus overvoltage did not raise the high-bus fault.");
  AST_LOW_BUS_GATED: assert property (@(posedge clk) disable iff (reset)
    $rose(faults_q[`F_LOBUS]) |-> $past(lowBusPersist && ctrl_q[`CTRL_LOWBUS_EN]))
    else $error("Low-bus fault rose without debounce or while disabled.");
  AST_ENC_PAIR: assert property (@(posedge clk) disable iff (reset)
    encPairBad && !rebootReq |=> faults_q[`F_ENCHW])
    else $error("Encoder pair at equal level did not fault.");
  AST_ENC_STICKY: assert property (@(posedge clk) disable iff (reset)
    sEncFault |=> faults_q[`F_ENCST])
    else $error("Encoder state fault cleared without a reboot.");
  AST_MOTOR_HOT: assert property (@(posedge clk) disable iff (reset)
    thermOpen && !rebootReq |=> faults_q[`F_MOTOT] ##1 code_q != 4'h0)
    else $error("Open thermal switch did not raise the motor fault.");
  AST_OVERSPEED: assert property (@(posedge clk) disable iff (reset)
    (motorSpeed > speedLimit_q) && !rebootReq |=> faults_q[`F_OVSPD])
    else $error("Speed above limit did not raise the overspeed fault.");
  AST_TRAVEL_AUTO: assert property (@(posedge clk) disable iff (reset)
    faults_q[`F_TRAVEL] && !trvPos && !trvNeg |=> !faults_q[`F_TRAVEL])
    else $error("Travel fault did not clear when the inputs went inactive.");
  AST_CLEAR_SHUNT: assert property (@(posedge clk) disable iff (reset)
    clearReq && !faultSet[`F_SHUNT] |=> !faults_q[`F_SHUNT])
    else $error("Reset request did not clear the shunt fault.");
  AST_PRIORITY: assert property (@(posedge clk) disable iff (reset)
    faults_q[`F_NVM] |=> code_q == 4'h1)
    else $error("Highest-priority fault not reported.");
endmodule
`default_nettype wire

/* fault_monitor_defs.svh */
// Constants for the servo drive fault monitor: offsets, field positions, reset values, timing.
`ifndef FAULT_MONITOR_DEFS_SVH
`define FAULT_MONITOR_DEFS_SVH

`define CLK_HZ 25000000
`define EN_TOGGLE_MAX_HZ 10
`define LOW_BUS_DEBOUNCE_MS 50
`define ALL_ON_MS 1000
`define EN_TOGGLE_CYCLES (`CLK_HZ / `EN_TOGGLE_MAX_HZ)
`define LOW_BUS_CYCLES (`CLK_HZ / 1000 * `LOW_BUS_DEBOUNCE_MS)
`define ALL_ON_CYCLES (`CLK_HZ / 1000 * `ALL_ON_MS - 2)
`define FE_DEFAULT_TENTHS_REV 2

`define AV_AW 8
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_CODE 8'h08
`define OFS_SPEED_LIM 8'h0C
`define OFS_FE_LIM 8'h10
`define OFS_SHUNT_LIM 8'h14

`define CTRL_LOWBUS_EN 0
`define CTRL_ENCST_EN 1
`define CTRL_FE_EN 2
`define CTRL_W 3
`define CTRL_RESET_VAL 3'h7
`define CTRL_CLEAR 8
`define CTRL_REBOOT 9
`define CODE_ALL_ON 8

`define SYNC_W 16
`define SYNC_RESET_VAL 16'h2150
`define SPEED_LIM_RESET 16'hFFFF
`define SHUNT_LIM_RESET 16'h8000

`define FAULT_W 11
`define F_NVM 0
`define F_PWR 1
`define F_HIBUS 2
`define F_LOBUS 3
`define F_ENCST 4
`define F_ENCHW 5
`define F_MOTOT 6
`define F_SHUNT 7
`define F_OVSPD 8
`define F_FOLERR 9
`define F_TRAVEL 10
`define CLEARABLE_MASK 11'h3CF
`define AUTO_MASK 11'h400

`endif

/* fault_monitor_pkg.sv */
// Types shared by the servo drive fault monitor.
`include "fault_monitor_defs.svh"
package fault_monitor_pkg;
  typedef enum logic [2:0] {
    NV_REQ = 3'b001,
    NV_ACC = 3'b010,
    NV_DONE = 3'b100
  } nvm_state_e;
  typedef logic [`FAULT_W-1:0] fault_vec_t;
  typedef logic [3:0] fault_code_t;
endpackage

/* sync_bank.sv */
// Two-flop synchroniser for a bank of asynchronous pin inputs.
`timescale 1ns/1ns
`default_nettype none
module sync_bank #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stable_q;

  // The first stage is read only by the second stage.
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= RESET_VAL;
      stable_q <= RESET_VAL;
    end else begin
      meta_q <= din;
      stable_q <= meta_q;
    end
  end

  assign dout = stable_q;
endmodule
`default_nettype wire

/* persist_timer.sv */
// Persistence timer: reports a level that has stood for a set number of cycles.
`timescale 1ns/1ns
`default_nettype none
module persist_timer #(
  parameter int unsigned LIMIT = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic level,
  output logic done
);
  logic [31:0] cnt_q;

  // Any dropout restarts the count, so short glitches never reach done.
  always_ff @(posedge clk) begin
    if (reset || !level) begin
      cnt_q <= 32'h00000000;
    end else if (cnt_q < LIMIT) begin
      cnt_q <= cnt_q + 32'h00000001;
    end
  end

  assign done = (cnt_q >= LIMIT);

  AST_PERSIST_NEEDS_LEVEL: assert property (@(posedge clk) disable iff (reset)
    $rose(done) |-> $past(level))
    else $error("Persistence reached without the level present.");
endmodule
`default_nettype wire

/* encoder_storage_model.sv */
// Behavioural model of the encoder lines and the storage memory facing the monitor.
`timescale 1ns/1ns
`default_nettype none
module encoder_storage_model (
  input wire logic clk,
  input wire logic corrupt,
  input wire logic step,
  input wire logic jump,
  input wire logic breakPair,
  input wire logic [2:0] nvmAddr,
  output logic [15:0] nvmData,
  output logic encA,
  output logic encAn,
  output logic encB,
  output logic encBn,
  output logic encZ,
  output logic encZn
);
  logic [1:0] posQ = 2'h0;
  // Words 0 and 1 sum to zero mod 2^16, so corrupt breaks the sum by one.
  always @(posedge clk) begin
    nvmData <= (nvmAddr == 3'h0) ? 16'h1234 + {15'h0, corrupt} :
               (nvmAddr == 3'h1) ? 16'hEDCC : 16'h0000;
    // A jump moves two quadrature states, so both lines change at once.
    posQ <= posQ + (jump ? 2'h2 : {1'b0, step});
  end
  assign encA = posQ[1];
  assign encB = posQ[1] ^ posQ[0];
  assign encAn = breakPair ? encA : ~encA;
  assign encBn = ~encB;
  assign encZ = 1'b0;
  assign encZn = 1'b1;
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking testbench for the servo drive fault monitor.
`timescale 1ns/1ns
`default_nettype none
`include "fault_monitor_defs.svh"
module testbench;
  logic clk = 1'b0, reset = 1'b1;
  logic [7:0] avsAddress = 8'h00;
  logic avsRead = 1'b0, avsWrite = 1'b0, avsWaitrequest;
  logic [31:0] avsWritedata = 32'h0, avsReaddata, rdata, ctrlV;
  logic pwrOverTemp = 1'b0, pwrOverCurrent = 1'b0, pwrLogicOk = 1'b1, driveEnable = 1'b1;
  logic busOverVolt = 1'b0, busUnderVolt = 1'b0, motorThermalOpen = 1'b0;
  logic travelPos = 1'b0, travelNeg = 1'b0, resetButton = 1'b0;
  logic encA, encAn, encB, encBn, encZ, encZn, allSegmentsOn, bridgeDisable;
  logic corrupt = 1'b0, step = 1'b0, jump = 1'b0, breakPair = 1'b0;
  logic [15:0] motorSpeed = 16'h0, shuntPowerRms = 16'h0, nvmData;
  logic signed [31:0] positionError = 32'sh0;
  logic [2:0] nvmAddr;
  logic [10:0] faultFlags;
  logic [3:0] faultCode;
  int fail_count = 0;
  int n_checks = 0;

  always #20 clk = ~clk;

  servo_drive_fault_monitor #(.EN_TOGGLE_CYCLES(50), .LOW_BUS_CYCLES(20),
    .ALL_ON_CYCLES(30), .NVM_AW(3)) dut_u (
    .clk(clk), .reset(reset), .avs_address(avsAddress), .avs_read(avsRead),
    .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_byteenable(4'hF),
    .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
    .pwrOverTemp(pwrOverTemp), .pwrOverCurrent(pwrOverCurrent), .pwrLogicOk(pwrLogicOk),
    .driveEnable(driveEnable), .busOverVolt(busOverVolt), .busUnderVolt(busUnderVolt),
    .encA(encA), .encAn(encAn), .encB(encB), .encBn(encBn), .encZ(encZ), .encZn(encZn),
    .motorThermalOpen(motorThermalOpen), .travelPos(travelPos), .travelNeg(travelNeg),
    .resetButton(resetButton), .motorSpeed(motorSpeed), .positionError(positionError),
    .shuntPowerRms(shuntPowerRms), .nvmAddr(nvmAddr), .nvmData(nvmData),
    .faultFlags(faultFlags), .faultCode(faultCode), .allSegmentsOn(allSegmentsOn),
    .bridgeDisable(bridgeDisable));

  encoder_storage_model model_u (.clk(clk), .corrupt(corrupt), .step(step), .jump(jump),
    .breakPair(breakPair), .nvmAddr(nvmAddr), .nvmData(nvmData), .encA(encA),
    .encAn(encAn), .encB(encB), .encBn(encBn), .encZ(encZ), .encZn(encZn));

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task chk(input logic [31:0] e, input logic [31:0] a);
    n_checks++;
    if (a !== e) begin
      $display("wrong value at %0t: expected %h got %h", $time, e, a);
      fail_count++;
    end
  endtask

  task chkF(input logic [10:0] e);
    chk({21'h0, e}, {21'h0, faultFlags});
  endtask

  // One access; the extra edge after release keeps back-to-back calls from
  // assigning a strobe twice in one time step.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= w;
    avsRead <= ~w;
    do begin
      @(posedge clk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 50);
    rdata = avsReaddata;
    if (n == 50)
      fail_count++;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge clk);
  endtask

  task setCtrl(input logic [31:0] v);
    ctrlV = v;
    bus(1'b1, `OFS_CTRL, v);
  endtask

  task clearAll;
    bus(1'b1, `OFS_CTRL, ctrlV | 32'h100);
    cyc(3);
  endtask

  task pressButton;
    resetButton <= 1'b1;
    cyc(6);
    resetButton <= 1'b0;
    cyc(4);
  endtask

  task pulseEn(input int n);
    driveEnable <= 1'b0;
    cyc(n / 2);
    driveEnable <= 1'b1;
    cyc(n / 2);
  endtask

  task kick(input logic j);
    jump <= j;
    step <= ~j;
    cyc(1);
    jump <= 1'b0;
    step <= 1'b0;
    cyc(5);
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // The whole sequence takes about 800 cycles.
  initial begin
    #(40 * 6000);
    fail_count++;
    summarize();
  end

  initial begin
    ctrlV = 32'h7;
    cyc(16);
    reset <= 1'b0;
    cyc(5);
    chk(32'h1, 32'(allSegmentsOn));
    cyc(40);
    chk(32'h0, 32'(allSegmentsOn));
    chkF(11'h000);
    bus(1'b0, `OFS_CTRL, 32'h0);
    chk(32'h7, rdata);
    bus(1'b0, `OFS_FE_LIM, 32'h0);
    chk(32'h333, rdata);
    bus(1'b0, 8'h20, 32'h0);
    chk(32'h0, rdata);
    corrupt <= 1'b1;
    bus(1'b1, `OFS_CTRL, 32'h207);
    cyc(60);
    chkF(11'h001);
    chk(32'h1, 32'(faultCode));
    chk(32'h1, 32'(bridgeDisable));
    corrupt <= 1'b0;
    clearAll();
    chkF(11'h000);
    $display("test power-up and storage done");
    for (int i = 0; i < 3; i++) begin
      pwrOverTemp <= (i == 0);
      pwrOverCurrent <= (i == 1);
      pwrLogicOk <= (i != 2);
      cyc(6);
      chkF(11'h002);
      pwrOverTemp <= 1'b0;
      pwrOverCurrent <= 1'b0;
      pwrLogicOk <= 1'b1;
      cyc(6);
      chkF(11'h002);
      clearAll();
      chkF(11'h000);
    end
    repeat (3) pulseEn(50);
    cyc(6);
    chkF(11'h000);
    repeat (2) pulseEn(48);
    cyc(6);
    chkF(11'h002);
    clearAll();
    $display("test power module done");
    busOverVolt <= 1'b1;
    cyc(6);
    chkF(11'h004);
    motorThermalOpen <= 1'b1;
    cyc(6);
    chkF(11'h044);
    chk(32'h3, 32'(faultCode));
    bus(1'b0, `OFS_STATUS, 32'h0);
    chk(32'h44, rdata);
    bus(1'b0, `OFS_CODE, 32'h0);
    chk(32'h3, rdata);
    busOverVolt <= 1'b0;
    cyc(4);
    pressButton();
    chkF(11'h040);
    chk(32'h7, 32'(faultCode));
    motorThermalOpen <= 1'b0;
    cyc(6);
    chkF(11'h040);
    clearAll();
    busUnderVolt <= 1'b1;
    cyc(18);
    busUnderVolt <= 1'b0;
    cyc(6);
    chkF(11'h000);
    busUnderVolt <= 1'b1;
    cyc(26);
    chkF(11'h008);
    busUnderVolt <= 1'b0;
    cyc(4);
    clearAll();
    setCtrl(32'h6);
    busUnderVolt <= 1'b1;
    cyc(30);
    chkF(11'h000);
    busUnderVolt <= 1'b0;
    // Let the synchroniser and the persistence timer drop before re-enabling.
    cyc(4);
    setCtrl(32'h7);
    $display("test bus and thermal done");
    bus(1'b1, `OFS_SHUNT_LIM, 32'h64);
    shuntPowerRms <= 16'h65;
    cyc(3);
    chkF(11'h080);
    shuntPowerRms <= 16'h0;
    bus(1'b1, `OFS_SPEED_LIM, 32'h3E8);
    clearAll();
    motorSpeed <= 16'h3E8;
    cyc(3);
    chkF(11'h000);
    motorSpeed <= 16'h3E9;
    cyc(3);
    chkF(11'h100);
    motorSpeed <= 16'h0;
    positionError <= 32'sh333;
    clearAll();
    chkF(11'h000);
    positionError <= -32'sh334;
    cyc(3);
    chkF(11'h200);
    positionError <= 32'sh0;
    clearAll();
    setCtrl(32'h3);
    positionError <= 32'sh384;
    cyc(3);
    chkF(11'h000);
    positionError <= 32'sh0;
    setCtrl(32'h7);
    travelNeg <= 1'b1;
    cyc(5);
    chkF(11'h400);
    chk(32'h0, 32'(bridgeDisable));
    travelNeg <= 1'b0;
    travelPos <= 1'b1;
    cyc(5);
    chkF(11'h400);
    travelPos <= 1'b0;
    cyc(5);
    chkF(11'h000);
    $display("test limits done");
    repeat (4) kick(1'b0);
    chkF(11'h000);
    setCtrl(32'h5);
    kick(1'b1);
    chkF(11'h000);
    setCtrl(32'h7);
    kick(1'b1);
    chkF(11'h010);
    breakPair <= 1'b1;
    cyc(5);
    chkF(11'h030);
    breakPair <= 1'b0;
    cyc(4);
    clearAll();
    pressButton();
    chkF(11'h030);
    bus(1'b1, `OFS_CTRL, 32'h207);
    cyc(60);
    chkF(11'h000);
    $display("test encoder done");
    summarize();
  end
endmodule
`default_nettype wire
